// ---- include/sadc_pkg.sv ----
// shared constants and types for the sampling converter link
`default_nettype none
package sadc_pkg;
	// word widths
	localparam int ADC_BITS  = 12;
	localparam int SER_BITS  = 16;
	localparam int BYTE_BITS = 8;
	localparam int HI_BITS   = ADC_BITS - BYTE_BITS;
	localparam int PAD_BITS  = SER_BITS - ADC_BITS;

	// serial bit timing, in link clock cycles per bit
	localparam int              PH_W    = 3;
	localparam logic [PH_W-1:0] PH_LOW  = 3'h4;
	localparam logic [PH_W-1:0] PH_LAST = 3'h7;
	localparam int               BIT_W    = 4;
	localparam logic [BIT_W-1:0] BIT_LAST = 4'hF;

	// format strap: word, bytes with gated clock, bytes with free clock
	typedef enum logic [1:0] {
		FMT_WORD       = 2'h0,
		FMT_BYTE_GATED = 2'h1,
		FMT_BYTE_CONT  = 2'h2
	} sadc_fmt_t;

	// device synchroniser layout and idle levels
	localparam int              DS_W   = 6;
	localparam int              DS_CST = 5;
	localparam int              DS_CS  = 4;
	localparam int              DS_RD  = 3;
	localparam int              DS_UBE = 2;
	localparam int              DS_FMT = 0;
	localparam logic [DS_W-1:0] DS_RST = 6'h38;

	// device states
	typedef enum logic [1:0] {
		D_IDLE = 2'h1,
		D_CONV = 2'h2
	} sadc_dst_t;

	// host timing, figures in ns, counts rounded up
	localparam int               MCLK_NS  = 40;
	localparam int               START_NS = 120;
	localparam int               READ_NS  = 400;
	localparam int               GAP_NS   = 200;
	localparam int               CNT_W    = 4;
	localparam logic [CNT_W-1:0] START_CYC =
		CNT_W'((START_NS + MCLK_NS - 1) / MCLK_NS);
	localparam logic [CNT_W-1:0] READ_CYC =
		CNT_W'((READ_NS + MCLK_NS - 1) / MCLK_NS);
	localparam logic [CNT_W-1:0] GAP_CYC =
		CNT_W'((GAP_NS + MCLK_NS - 1) / MCLK_NS);

	// host synchroniser layout: busy, clock, data, strobe, bus
	localparam int              HS_W    = ADC_BITS + 4;
	localparam int              HS_BUSY = 15;
	localparam int              HS_SCK  = 14;
	localparam int              HS_SDAT = 13;
	localparam int              HS_STRB = 12;
	localparam logic [HS_W-1:0] HS_RST  = 16'hF000;

	// host states
	typedef enum logic [5:0] {
		H_IDLE    = 6'h01,
		H_PULSE   = 6'h02,
		H_WAIT_LO = 6'h04,
		H_WAIT_HI = 6'h08,
		H_READ    = 6'h10,
		H_GAP     = 6'h20
	} sadc_hst_t;
endpackage
`default_nettype wire

// ---- include/sadc_link_if.sv ----
// link between the converter end and the host end
`timescale 1ns/10ps
`default_nettype none
interface sadc_link_if;
	import sadc_pkg::*;
	// host driven lines
	logic                conv_start_n;
	logic                cs_n;
	logic                rd_n;
	logic                upper_byte_sel;
	sadc_fmt_t           fmt_sel;
	// converter driven lines
	logic [ADC_BITS-1:0] data_out;
	logic                data_oe;
	logic [ADC_BITS-1:0] data_bus;
	logic                busy_int_n;
	logic                serial_clk_oe;
	logic                serial_clk;
	logic                serial_out_line_oe;
	logic                serial_out_line;
	logic                serial_frame_strobe_oe;
	logic                serial_frame_strobe_n;

	// bus reads zero when released; open-drain lines pull up
	assign data_bus              = data_oe ? data_out : '0;
	assign serial_clk            = ~serial_clk_oe;
	assign serial_out_line       = ~serial_out_line_oe;
	assign serial_frame_strobe_n = ~serial_frame_strobe_oe;

	modport dev (
		input  conv_start_n, cs_n, rd_n, upper_byte_sel, fmt_sel,
		output data_out, data_oe, busy_int_n, serial_clk_oe,
		output serial_out_line_oe, serial_frame_strobe_oe
	);
	modport host (
		output conv_start_n, cs_n, rd_n, upper_byte_sel, fmt_sel,
		input  data_bus, busy_int_n, serial_clk, serial_out_line,
		input  serial_frame_strobe_n
	);
endinterface
`default_nettype wire

// ---- verilog/sadc_dev.sv ----
// converter end: conversion timing, parallel, byte and serial output
`timescale 1ns/10ps
`default_nettype none
// Function
// - timer start converts, done flag at end
// - host may decode start from address
// - host never reads during conversion; here a select-mode read is held through it
// - byte bus: strap low, address drives byte
// - busy with select holds host waiting
// - only the first byte access waits
// - first byte low, then high byte
// - strap low gates serial clock, data
// - gated data valid at first falling edge
// - free clock, strobe frames the word
// - shift during conversion, receiver takes sixteen
// - receiver samples on falling clock edge
// - done flag low, cleared by read
// - busy low throughout select-started conversion
// - select start with start held low
module sadc_dev (
	// link clock and reset
	input  wire logic                          LCLK,
	input  wire logic                          RSTN,
	input  wire logic                          CLK_EN,
	// sample held at conversion start
	input  wire logic [sadc_pkg::ADC_BITS-1:0] SAMPLE,
	// local view of the converted word
	output var  logic [sadc_pkg::ADC_BITS-1:0] RESULT,
	output var  logic                          RESULT_VALID,
	output var  logic                          CONVERTING,
	// link to the host
	sadc_link_if.dev                           LINK
);
	import sadc_pkg::*;

	logic [DS_W-1:0]     sync1_q;
	logic [DS_W-1:0]     sync2_q;
	logic                cst_q;
	logic                acc_q;
	logic                cs_q;
	logic [PH_W-1:0]     ph_q;
	logic [BIT_W-1:0]    bit_q;
	sadc_dst_t           state_q;
	logic                pend_q;
	logic                mode2_q;
	logic [ADC_BITS-1:0] hold_q;
	logic [ADC_BITS-1:0] samp1_q;
	logic [ADC_BITS-1:0] samp2_q;
	logic [SER_BITS-1:0] shift_q;
	logic                cst_n;
	logic                cs_low;
	logic                acc;
	logic                ube;
	sadc_fmt_t           fmt;
	logic                idle;
	logic                conv;
	logic                start_m1;
	logic                start_m2;
	logic                enter;
	logic                bit_tick;
	logic                eoc;
	logic                acc_rise;

	// host lines and the sample come from another clock: two flops first;
	// the sample must stand still a few link cycles before a start is
	// seen, otherwise a word caught mid-change could be held
	always_ff @(posedge LCLK or negedge RSTN) begin
		if (!RSTN) begin
			sync1_q <= DS_RST;
			sync2_q <= DS_RST;
			samp1_q <= '0;
			samp2_q <= '0;
		end else if (CLK_EN) begin
			sync1_q <= {LINK.conv_start_n, LINK.cs_n, LINK.rd_n,
				LINK.upper_byte_sel, LINK.fmt_sel};
			sync2_q <= sync1_q;
			samp1_q <= SAMPLE;
			samp2_q <= samp1_q;
		end
	end

	// decoded link levels
	assign cst_n  = sync2_q[DS_CST];
	assign cs_low = ~sync2_q[DS_CS];
	assign acc    = cs_low & ~sync2_q[DS_RD];
	assign ube    = sync2_q[DS_UBE];
	assign fmt    = sadc_fmt_t'(sync2_q[DS_FMT +: 2]);
	assign idle   = (state_q == D_IDLE);
	assign conv   = (state_q == D_CONV);

	// edge history for start and access detection
	always_ff @(posedge LCLK or negedge RSTN) begin
		if (!RSTN) begin
			cst_q <= 1'b1;
			acc_q <= 1'b0;
			cs_q  <= 1'b0;
		end else if (CLK_EN) begin
			cst_q <= cst_n;
			acc_q <= acc;
			cs_q  <= cs_low;
		end
	end

	assign start_m1 = cst_n & ~cst_q;
	assign start_m2 = cs_low & ~cs_q & ~ube & ~cst_n;
	assign acc_rise = acc & ~acc_q;
	assign enter    = idle & pend_q & (ph_q == PH_LAST);
	assign bit_tick = conv & (ph_q == PH_LAST);
	assign eoc      = bit_tick & (bit_q == BIT_LAST);

	// free-running bit phase, so a free serial clock never stops
	always_ff @(posedge LCLK or negedge RSTN) begin
		if (!RSTN) begin
			ph_q <= '0;
		end else if (CLK_EN) begin
			ph_q <= ph_q + 3'h1;
		end
	end

	// start request waits for the next bit boundary
	always_ff @(posedge LCLK or negedge RSTN) begin
		if (!RSTN) begin
			pend_q  <= 1'b0;
			mode2_q <= 1'b0;
		end else if (CLK_EN) begin
			if (idle && (start_m1 || start_m2)) begin
				pend_q  <= 1'b1;
				mode2_q <= start_m2;
			end else if (enter) begin
				pend_q <= 1'b0;
			end
		end
	end

	// conversion sequencing, one serial bit per step
	always_ff @(posedge LCLK or negedge RSTN) begin
		if (!RSTN) begin
			state_q <= D_IDLE;
			bit_q   <= '0;
		end else if (CLK_EN) begin
			case (state_q)
				D_IDLE: begin
					if (enter) begin
						state_q <= D_CONV;
						bit_q   <= '0;
					end
				end
				D_CONV: begin
					if (eoc) begin
						state_q <= D_IDLE;
					end else if (bit_tick) begin
						bit_q <= bit_q + 4'h1;
					end
				end
				default: begin
					state_q <= D_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge LCLK or negedge RSTN) begin
		if (!RSTN) begin
			hold_q  <= '0;
			shift_q <= '0;
		end else if (CLK_EN) begin
			if (enter) begin
				hold_q  <= samp2_q;
				shift_q <= {{PAD_BITS{1'b0}}, samp2_q};
			end else if (bit_tick) begin
				shift_q <= {shift_q[SER_BITS-2:0], 1'b0};
			end
		end
	end

	// result appears only when the conversion ends
	always_ff @(posedge LCLK or negedge RSTN) begin
		if (!RSTN) begin
			RESULT       <= '0;
			RESULT_VALID <= 1'b0;
			CONVERTING   <= 1'b0;
		end else if (CLK_EN) begin
			RESULT_VALID <= eoc;
			CONVERTING   <= conv;
			if (eoc) begin
				RESULT <= hold_q;
			end
		end
	end

	// done flag or busy; end of conversion beats a clearing read
	always_ff @(posedge LCLK or negedge RSTN) begin
		if (!RSTN) begin
			LINK.busy_int_n <= 1'b1;
		end else if (CLK_EN) begin
			if (eoc) begin
				LINK.busy_int_n <= mode2_q;
			end else if (idle && start_m2) begin
				LINK.busy_int_n <= 1'b0;
			end else if (acc_rise && !mode2_q) begin
				LINK.busy_int_n <= 1'b1;
			end
		end
	end

	// parallel bus driven while select and read are low
	always_ff @(posedge LCLK or negedge RSTN) begin
		if (!RSTN) begin
			LINK.data_oe  <= 1'b0;
			LINK.data_out <= '0;
		end else if (CLK_EN) begin
			LINK.data_oe <= acc;
			if (fmt == FMT_WORD) begin
				LINK.data_out <= RESULT;
			end else if (ube) begin
				LINK.data_out <= {{BYTE_BITS{1'b0}},
					RESULT[ADC_BITS-1:BYTE_BITS]};
			end else begin
				// low byte read first, the access that waits on busy
				LINK.data_out <= {{HI_BITS{1'b0}},
					RESULT[BYTE_BITS-1:0]};
			end
		end
	end

	// serial lines: data moves as the clock rises, stable at the fall
	always_ff @(posedge LCLK or negedge RSTN) begin
		if (!RSTN) begin
			LINK.serial_clk_oe          <= 1'b0;
			LINK.serial_out_line_oe     <= 1'b0;
			LINK.serial_frame_strobe_oe <= 1'b0;
		end else if (CLK_EN) begin
			LINK.serial_clk_oe <= (fmt != FMT_WORD)
				& (conv | (fmt == FMT_BYTE_CONT))
				& (ph_q >= PH_LOW);
			// first bit set before first fall
			LINK.serial_out_line_oe <= (fmt != FMT_WORD)
				& conv & ~shift_q[SER_BITS-1];
			LINK.serial_frame_strobe_oe <= conv
				& (fmt == FMT_BYTE_CONT);
		end
	end
endmodule // sadc_dev
`default_nettype wire

// ---- verilog/sadc_host.sv ----
// host end: starts conversions, reads words or bytes, takes serial
`timescale 1ns/10ps
`default_nettype none
module sadc_host (
	// host clock and reset
	input  wire logic                          MCLK,
	input  wire logic                          RSTN,
	input  wire logic                          CLK_EN,
	// conversion request and straps
	input  wire logic                          START,
	input  wire logic                          SEL_START,
	input  wire sadc_pkg::sadc_fmt_t           FMT,
	// parallel result
	output var  logic [sadc_pkg::ADC_BITS-1:0] WORD,
	output var  logic                          WORD_VALID,
	output var  logic                          BUSY,
	// serial result
	output var  logic [sadc_pkg::SER_BITS-1:0] SER_WORD,
	output var  logic                          SER_VALID,
	// link to the converter
	sadc_link_if.host                          LINK
);
	import sadc_pkg::*;

	logic [HS_W-1:0]     hs1_q;
	logic [HS_W-1:0]     hs2_q;
	sadc_hst_t           state_q;
	logic [CNT_W-1:0]    cnt_q;
	logic                sel_q;
	logic                byte_q;
	logic                two_bytes;
	logic                sck_q;
	logic                sck_fall;
	logic [SER_BITS-1:0] sh_q;
	logic [BIT_W-1:0]    nbit_q;

	// converter lines cross clocks through two flops
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			hs1_q <= HS_RST;
			hs2_q <= HS_RST;
		end else if (CLK_EN) begin
			hs1_q <= {LINK.busy_int_n, LINK.serial_clk,
				LINK.serial_out_line, LINK.serial_frame_strobe_n,
				LINK.data_bus};
			hs2_q <= hs1_q;
		end
	end

	// byte formats read twice and listen on the serial lines
	assign two_bytes = (LINK.fmt_sel != FMT_WORD);

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			LINK.fmt_sel <= FMT_WORD;
		end else if (CLK_EN) begin
			LINK.fmt_sel <= FMT;
		end
	end

	// request sequencer
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			state_q             <= H_IDLE;
			cnt_q               <= '0;
			sel_q               <= 1'b0;
			byte_q              <= 1'b0;
			WORD                <= '0;
			WORD_VALID          <= 1'b0;
			BUSY                <= 1'b0;
			LINK.conv_start_n   <= 1'b1;
			LINK.cs_n           <= 1'b1;
			LINK.rd_n           <= 1'b1;
			LINK.upper_byte_sel <= 1'b0;
		end else if (CLK_EN) begin
			WORD_VALID <= 1'b0;
			case (state_q)
				H_IDLE: begin
					// start held low in select mode
					LINK.conv_start_n <= ~SEL_START;
					if (START) begin
						sel_q  <= SEL_START;
						byte_q <= 1'b0;
						BUSY   <= 1'b1;
						if (SEL_START) begin
							LINK.cs_n <= 1'b0;
							LINK.rd_n <= 1'b0;
							state_q   <= H_WAIT_LO;
						end else begin
							LINK.conv_start_n <= 1'b0;
							cnt_q             <= START_CYC;
							state_q           <= H_PULSE;
						end
					end
				end
				H_PULSE: begin
					if (cnt_q == '0) begin
						LINK.conv_start_n <= 1'b1;
						state_q           <= H_WAIT_LO;
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				H_WAIT_LO: begin
					// no read until the done flag
					if (!hs2_q[HS_BUSY]) begin
						if (sel_q) begin
							state_q <= H_WAIT_HI;
						end else begin
							LINK.cs_n <= 1'b0;
							LINK.rd_n <= 1'b0;
							cnt_q     <= READ_CYC;
							state_q   <= H_READ;
						end
					end
				end
				H_WAIT_HI: begin
					if (hs2_q[HS_BUSY]) begin
						cnt_q   <= READ_CYC;
						state_q <= H_READ;
					end
				end
				H_READ: begin
					if (cnt_q == '0) begin
						if (!two_bytes) begin
							WORD <= hs2_q[ADC_BITS-1:0];
						end else if (!byte_q) begin
							WORD[BYTE_BITS-1:0] <= hs2_q[BYTE_BITS-1:0];
							LINK.upper_byte_sel <= 1'b1;
						end else begin
							WORD[ADC_BITS-1:BYTE_BITS] <=
								hs2_q[HI_BITS-1:0];
						end
						LINK.cs_n <= 1'b1;
						LINK.rd_n <= 1'b1;
						cnt_q     <= GAP_CYC;
						state_q   <= H_GAP;
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				H_GAP: begin
					if (cnt_q != '0) begin
						cnt_q <= cnt_q - 4'h1;
					end else if (two_bytes && !byte_q) begin
						byte_q    <= 1'b1;
						LINK.cs_n <= 1'b0;
						LINK.rd_n <= 1'b0;
						cnt_q     <= READ_CYC;
						state_q   <= H_READ;
					end else begin
						LINK.upper_byte_sel <= 1'b0;
						WORD_VALID          <= 1'b1;
						BUSY                <= 1'b0;
						state_q             <= H_IDLE;
					end
				end
				default: begin
					state_q <= H_IDLE;
				end
			endcase
		end
	end

	assign sck_fall = sck_q & ~hs2_q[HS_SCK];

	// serial receiver; a free clock only counts inside the strobe
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			sck_q     <= 1'b1;
			sh_q      <= '0;
			nbit_q    <= '0;
			SER_WORD  <= '0;
			SER_VALID <= 1'b0;
		end else if (CLK_EN) begin
			sck_q     <= hs2_q[HS_SCK];
			SER_VALID <= 1'b0;
			if ((LINK.fmt_sel == FMT_BYTE_CONT) && hs2_q[HS_STRB]) begin
				nbit_q <= '0;
			end else if (sck_fall && two_bytes) begin
				sh_q   <= {sh_q[SER_BITS-2:0], hs2_q[HS_SDAT]};
				nbit_q <= nbit_q + 4'h1;
				if (nbit_q == BIT_LAST) begin
					SER_WORD  <= {sh_q[SER_BITS-2:0], hs2_q[HS_SDAT]};
					SER_VALID <= 1'b1;
				end
			end
		end
	end
endmodule // sadc_host
`default_nettype wire

// ---- bench/sadc_checker.sv ----
// concurrent checks on the converter link
`timescale 1ns/10ps
`default_nettype none
module sadc_checker (
	// clocks and reset
	input wire logic                lclk,
	input wire logic                mclk,
	input wire logic                rstn,
	// host driven lines
	input wire logic                conv_start_n,
	input wire logic                cs_n,
	input wire logic                rd_n,
	input wire logic                upper_byte_sel,
	input wire sadc_pkg::sadc_fmt_t fmt_sel,
	// converter driven lines
	input wire logic                data_oe,
	input wire logic                busy_int_n,
	input wire logic                serial_clk_oe,
	input wire logic                serial_out_line_oe,
	input wire logic                serial_frame_strobe_oe
);
	import sadc_pkg::*;
	logic [7:0] low_q;
	logic [4:0] still_q;
	logic       sck_q;

	// busy low length, saturates so a stuck flag cannot wrap
	always_ff @(posedge lclk or negedge rstn) begin
		if (!rstn) begin
			low_q <= 8'h00;
		end else if (busy_int_n) begin
			low_q <= 8'h00;
		end else if (low_q != 8'hFF) begin
			low_q <= low_q + 8'h01;
		end
	end

	// cycles since the serial clock last moved
	always_ff @(posedge lclk or negedge rstn) begin
		if (!rstn) begin
			sck_q   <= 1'b0;
			still_q <= 5'h00;
		end else begin
			sck_q <= serial_clk_oe;
			if (sck_q != serial_clk_oe) begin
				still_q <= 5'h00;
			end else if (still_q != 5'h1F) begin
				still_q <= still_q + 5'h01;
			end
		end
	end

	// a timer-mode read held selected
	sequence read_held_s;
		conv_start_n && !cs_n && !rd_n;
	endsequence

	word_quiet_a: assert property (@(posedge lclk) disable iff (!rstn)
		fmt_sel == FMT_WORD |-> !(serial_clk_oe || serial_out_line_oe
		|| serial_frame_strobe_oe))
		else $error("serial line active in word format");
	clk_low_width_a: assert property (@(posedge lclk)
		disable iff (!rstn) $rose(serial_clk_oe) |-> serial_clk_oe[*3])
		else $error("serial clock low phase too short");
	data_steady_a: assert property (@(posedge lclk)
		disable iff (!rstn) serial_clk_oe && $past(serial_clk_oe)
		|-> $stable(serial_out_line_oe))
		else $error("serial data moved while clock low");
	strobe_cont_a: assert property (@(posedge lclk)
		disable iff (!rstn) serial_frame_strobe_oe
		|-> fmt_sel == FMT_BYTE_CONT)
		else $error("strobe outside continuous format");
	clock_runs_a: assert property (@(posedge lclk)
		disable iff (!rstn) fmt_sel == FMT_BYTE_CONT |-> still_q < 5'h18)
		else $error("continuous serial clock stopped");
	busy_span_a: assert property (@(posedge lclk)
		disable iff (!rstn) $rose(busy_int_n) && !conv_start_n
		|-> low_q >= 8'h80 && low_q <= 8'h8C)
		else $error("busy low span not one conversion");
	done_hold_a: assert property (@(posedge lclk)
		disable iff (!rstn) conv_start_n && cs_n && !busy_int_n
		|=> !busy_int_n)
		else $error("done flag dropped without a read");
	done_clear_a: assert property (@(posedge lclk)
		disable iff (!rstn) read_held_s [*6] |-> busy_int_n)
		else $error("done flag not cleared by read");
	bus_release_a: assert property (@(posedge lclk)
		disable iff (!rstn) cs_n [*5] |-> !data_oe)
		else $error("data bus driven while deselected");
	byte_nowait_a: assert property (@(posedge lclk)
		disable iff (!rstn) upper_byte_sel && !cs_n |-> busy_int_n)
		else $error("wait state on upper byte read");
	cs_rd_pair_a: assert property (@(posedge mclk)
		disable iff (!rstn) cs_n == rd_n)
		else $error("select and read strobe apart");
endmodule // sadc_checker
`default_nettype wire

// ---- bench/test_sampling_adc_host_interface.sv ----
// self-checking bench joining converter end and host end
`timescale 1ns/10ps
`default_nettype none
module test_sampling_adc_host_interface;
	import sadc_pkg::*;
	logic                MCLK        = 1'b0;
	logic                LCLK        = 1'b0;
	logic                RSTN        = 1'b0;
	logic                START       = 1'b0;
	logic                SEL_START   = 1'b0;
	logic                CLK_EN      = 1'b1;
	sadc_fmt_t           FMT         = FMT_WORD;
	logic [ADC_BITS-1:0] SAMPLE      = 12'h000;
	logic [ADC_BITS-1:0] RESULT;
	logic [ADC_BITS-1:0] WORD;
	logic [ADC_BITS-1:0] res_seen;
	logic [SER_BITS-1:0] SER_WORD;
	logic [SER_BITS-1:0] ser_seen;
	logic                RESULT_VALID;
	logic                CONVERTING;
	logic                WORD_VALID;
	logic                BUSY;
	logic                SER_VALID;
	logic [ADC_BITS-1:0] vals [3] = '{12'h801, 12'h000, 12'hFFF};
	int                  num_errors  = 0;
	int                  check_count = 0;
	int                  ser_cnt     = 0;
	int                  res_cnt     = 0;
	int                  conv_cyc    = 0;

	// two free-running clocks, periods 40 ns and 30 ns, so edges meet every 60 ns
	always #20 MCLK = ~MCLK;
	always #15 LCLK = ~LCLK;

	sadc_link_if u_sadc_link_if ();
	sadc_dev u_sadc_dev (.LCLK(LCLK), .RSTN(RSTN), .CLK_EN(1'b1),
		.SAMPLE(SAMPLE), .RESULT(RESULT), .RESULT_VALID(RESULT_VALID),
		.CONVERTING(CONVERTING), .LINK(u_sadc_link_if.dev));
	sadc_host u_sadc_host (.MCLK(MCLK), .RSTN(RSTN), .CLK_EN(CLK_EN),
		.START(START), .SEL_START(SEL_START), .FMT(FMT), .WORD(WORD),
		.WORD_VALID(WORD_VALID), .BUSY(BUSY), .SER_WORD(SER_WORD),
		.SER_VALID(SER_VALID), .LINK(u_sadc_link_if.host));
	sadc_checker u_sadc_checker (.lclk(LCLK), .mclk(MCLK), .rstn(RSTN),
		.conv_start_n(u_sadc_link_if.conv_start_n),
		.cs_n(u_sadc_link_if.cs_n), .rd_n(u_sadc_link_if.rd_n),
		.upper_byte_sel(u_sadc_link_if.upper_byte_sel),
		.fmt_sel(u_sadc_link_if.fmt_sel),
		.data_oe(u_sadc_link_if.data_oe),
		.busy_int_n(u_sadc_link_if.busy_int_n),
		.serial_clk_oe(u_sadc_link_if.serial_clk_oe),
		.serial_out_line_oe(u_sadc_link_if.serial_out_line_oe),
		.serial_frame_strobe_oe(u_sadc_link_if.serial_frame_strobe_oe));

	// serial words arrive mid-conversion, so they are caught here
	always @(negedge MCLK) begin
		if (SER_VALID === 1'b1) begin
			ser_seen <= SER_WORD;
			ser_cnt  <= ser_cnt + 1;
		end
	end

	// converter side result pulses and length of each conversion
	always @(negedge LCLK) begin
		if (RESULT_VALID === 1'b1) begin
			res_seen <= RESULT;
			res_cnt  <= res_cnt + 1;
		end
		if (CONVERTING === 1'b1) begin
			conv_cyc <= conv_cyc + 1;
		end
	end

	// compare and count
	task automatic check(input logic [SER_BITS-1:0] seen,
		input logic [SER_BITS-1:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// verdict and end of run
	task automatic final_report();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// straps only change under reset, so no stray timer start is seen
	task automatic do_reset(input logic sel, input sadc_fmt_t fmt);
		@(negedge MCLK);
		RSTN      = 1'b0;
		SEL_START = sel;
		FMT       = fmt;
		repeat (10) @(negedge MCLK);
		check(16'({u_sadc_link_if.busy_int_n, u_sadc_link_if.data_oe,
			u_sadc_link_if.serial_clk, u_sadc_link_if.serial_out_line,
			u_sadc_link_if.serial_frame_strobe_n, u_sadc_link_if.cs_n,
			u_sadc_link_if.conv_start_n, u_sadc_link_if.rd_n,
			u_sadc_link_if.upper_byte_sel}), 16'h017E);
		RSTN = 1'b1;
		repeat (4) @(negedge MCLK);
		// a frozen host must not take a request
		CLK_EN = 1'b0;
		START  = 1'b1;
		repeat (8) @(negedge MCLK);
		START  = 1'b0;
		CLK_EN = 1'b1;
		check(16'(BUSY), 16'h0000);
		check(16'(u_sadc_link_if.cs_n), 16'h0001);
	endtask

	// one request, then every view of the result
	task automatic convert(input logic [ADC_BITS-1:0] val);
		int s0;
		int r0;
		int n;
		int c0;
		s0     = ser_cnt;
		r0     = res_cnt;
		c0     = conv_cyc;
		SAMPLE = val;
		START  = 1'b1;
		@(negedge MCLK);
		START = 1'b0;
		check(16'(BUSY), 16'h0001);
		n = 0;
		while (WORD_VALID !== 1'b1 && n < 4000) begin
			@(negedge MCLK);
			n++;
		end
		check(16'(WORD_VALID), 16'h0001);
		check(16'(WORD), 16'(val));
		check(16'(BUSY), 16'h0000);
		check(16'(u_sadc_link_if.data_bus), 16'h0000);
		check(16'(res_cnt - r0), 16'h0001);
		check(16'(res_seen), 16'(val));
		check(16'(conv_cyc - c0), 16'(SER_BITS * (int'(PH_LAST) + 1)));
		check(16'(ser_cnt - s0), FMT == FMT_WORD ? 16'h0000 : 16'h0001);
		if (FMT != FMT_WORD) begin
			check(ser_seen, {{PAD_BITS{1'b0}}, val});
		end
	endtask

	// timer mode first, then select mode, each in all three formats
	initial begin
		for (int m = 0; m < 2; m++) begin
			for (int f = 0; f < 3; f++) begin
				do_reset(m[0], sadc_fmt_t'(f));
				for (int v = 0; v < 3; v++) begin
					convert(vals[v]);
				end
			end
		end
		final_report();
	end

	// cut a hang short
	initial begin
		#(MCLK_NS * 20000);
		num_errors++;
		final_report();
	end
endmodule // test_sampling_adc_host_interface
`default_nettype wire
